/* File: rtl/sse_exec.sv */
// How it works
// - shift left on positive count, right on negative
// - carry takes the last bit shifted out
// - byte size register count spans -8..+8
// - word and long counts span -16..+16
// - zero count changes neither operand nor flags
// - sign is result msb, zero flags zero result
// - copy down reads source, writes destination, decrements
// - copy up does the same but increments
// - source is bank above pointer, count from register
// - step 1 or 2, count drops by one
// - source pointer wrap moves bank by one
// - zero count at start does nothing
// - interrupt taken between elements, state kept
// - pointers end just past the last element
// - fill writes byte or word, steps destination
// - control store to register or low-first memory
// - program counter stores three bytes, others two
// - stack pointer source follows the stack-select flag
//
// The placing of the registers and the strobed register port were left to the implementer.
module sse_exec (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire logic [sse_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [sse_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [sse_pkg::DATA_W-1:0] O_RDATA,
  output logic [sse_pkg::MEM_AW-1:0] O_MEM_ADDR,
  output logic O_MEM_RD,
  output logic O_MEM_WR,
  output logic O_MEM_WORD,
  output logic [sse_pkg::DATA_W-1:0] O_MEM_WDATA,
  input wire logic [sse_pkg::DATA_W-1:0] I_MEM_RDATA,
  input wire logic I_IRQ,
  output logic O_IRQ_ACK,
  output logic O_BUSY
);
  import sse_pkg::*;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RSTN);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sse_state_t state_r;
  sse_op_t op_r;
  sse_size_t size_r;
  sse_creg_t sel_r;
  logic memdst_r;
  logic [7:0] flg_r;
  logic [BANK_W-1:0] bank_r;
  logic [15:0] src_r;
  logic [15:0] dst_r;
  logic [15:0] cnt_r;
  logic [15:0] fill_r;
  logic [SHV_W-1:0] shv_r;
  logic [SHC_W-1:0] shc_r;
  logic [MEM_AW-1:0] cres_r;
  logic [DATA_W-1:0] ctl_r [CTL_N];
  logic [1:0] bidx_r;
  logic first_r;
  logic susp_r;
  logic done_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic [15:0] src_nxt;
  logic [15:0] dst_nxt;
  logic [BANK_W-1:0] bank_nxt;
  logic idle;
  logic sw_wr;
  logic start;
  logic down;
  logic wide;
  logic irq_take;
  logic issue;
  logic step_src;
  logic step_dst;
  logic shift_live;
  sse_op_t cmd_op;
  logic [23:0] creg_val;
  logic [1:0] nbytes;
  logic [SHV_W-1:0] shm;

  sse_shf_if shf ();

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // software owns the operand registers only while the engine is idle,
  // which keeps one writer per register without a priority scheme
  assign idle = state_r == S_IDLE;
  assign sw_wr = I_WR && idle;
  assign cmd_op = sse_op_t'(I_WDATA[CTRL_OP_LSB +: CTRL_OP_W]);
  assign start = sw_wr && I_ADDR == OFF_CTRL && I_WDATA[CTRL_START];
  assign down = op_r == OP_COPY_DN;
  assign wide = size_r != SZ_B;
  assign irq_take = irq_s2_r && !first_r && cnt_r != CNT_ZERO;
  assign issue = state_r == S_NEXT && cnt_r != CNT_ZERO && !irq_take;
  assign step_src = state_r == S_XFER;
  assign step_dst = step_src || (issue && op_r == OP_FILL);
  assign nbytes = (sel_r == CR_PC) ? BYTES_PC : BYTES_OTHER;
  assign shift_live = state_r == S_SHIFT && shc_r != SHC_ZERO;
  assign shm = sse_mask(size_r);

  assign shf.val = shv_r;
  assign shf.cnt = shc_r;
  assign shf.size = size_r;

  always_comb begin
    unique case (sel_r)
      CR_FB: creg_val = 24'(ctl_r[CI_FB]);
      CR_SB: creg_val = 24'(ctl_r[CI_SB]);
      CR_SP: creg_val = flg_r[FLG_U] ? 24'(ctl_r[CI_USP]) : 24'(ctl_r[CI_ISP]);
      CR_ISP: creg_val = 24'(ctl_r[CI_ISP]);
      CR_FLG: creg_val = 24'(flg_r);
      CR_VECTOR_TABLE_BASE_HIGH: creg_val = 24'(ctl_r[CI_VECTOR_TABLE_BASE_HIGH][HI_W-1:0]);
      CR_VECTOR_TABLE_BASE_LOW: creg_val = 24'(ctl_r[CI_VECTOR_TABLE_BASE_LOW]);
      CR_PC: creg_val = 24'({ctl_r[CI_PC_HI][HI_W-1:0], ctl_r[CI_PC_LO]});
    endcase
  end

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] d;
    d = '0;
    if (a >= OFF_CTL_BASE && a < OFF_CTL_BASE + ADDR_W'(CTL_N)) begin
      d = ctl_r[3'(a - OFF_CTL_BASE)];
    end else begin
      case (a)
        OFF_CTRL: d = DATA_W'({sel_r, 2'h0, memdst_r, size_r, op_r}) << 0;
        OFF_STATUS: d = DATA_W'({done_r, susp_r, !idle});
        OFF_FLAGS: d = DATA_W'(flg_r);
        OFF_BANK: d = DATA_W'(bank_r);
        OFF_SRC: d = src_r;
        OFF_DST: d = dst_r;
        OFF_COUNT: d = cnt_r;
        OFF_FILL: d = fill_r;
        OFF_SHV_LO: d = shv_r[DATA_W-1:0];
        OFF_SHV_HI: d = shv_r[SHV_W-1:DATA_W];
        OFF_SHC: d = DATA_W'(shc_r);
        OFF_CRES_LO: d = cres_r[DATA_W-1:0];
        OFF_CRES_HI: d = DATA_W'(cres_r[MEM_AW-1:DATA_W]);
        default: d = '0;
      endcase
    end
    return d;
  endfunction

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  sse_shift u_shift (
    .sif(shf)
  );

  sse_step #(.PW(16), .BW(BANK_W)) u_src_step (
    .i_ptr(src_r),
    .i_bank(bank_r),
    .i_down(down),
    .i_wide(wide),
    .o_ptr(src_nxt),
    .o_bank(bank_nxt)
  );

  sse_step #(.PW(16), .BW(BANK_W)) u_dst_step (
    .i_ptr(dst_r),
    .i_bank('0),
    .i_down(down),
    .i_wide(wide),
    .o_ptr(dst_nxt),
    .o_bank()
  );

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RDATA <= '0;
    end else begin
      O_RDATA <= I_RD ? read_word(I_ADDR) : '0;
    end
  end

  for (genvar i = 0; i < CTL_N; i++) begin : g_ctl
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
      if (!I_RSTN) begin
        ctl_r[i] <= '0;
      end else if (sw_wr && I_ADDR == OFF_CTL_BASE + ADDR_W'(i)) begin
        if (i == CI_VECTOR_TABLE_BASE_HIGH || i == CI_PC_HI) begin
          ctl_r[i] <= DATA_W'(I_WDATA[HI_W-1:0]);
        end else begin
          ctl_r[i] <= I_WDATA;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      op_r <= OP_NONE;
      size_r <= SZ_B;
      sel_r <= CR_FB;
      memdst_r <= 1'b0;
    end else if (start) begin
      op_r <= cmd_op;
      size_r <= sse_size_t'(I_WDATA[CTRL_SIZE_LSB +: CTRL_SIZE_W]);
      sel_r <= sse_creg_t'(I_WDATA[CTRL_SEL_LSB +: CTRL_SEL_W]);
      memdst_r <= I_WDATA[CTRL_MEMDST];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= I_IRQ;
      irq_s2_r <= irq_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // shift operand and flags
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      shv_r <= '0;
      shc_r <= '0;
    end else begin
      if (sw_wr && I_ADDR == OFF_SHV_LO) shv_r[DATA_W-1:0] <= I_WDATA;
      if (sw_wr && I_ADDR == OFF_SHV_HI) shv_r[SHV_W-1:DATA_W] <= I_WDATA;
      if (sw_wr && I_ADDR == OFF_SHC) shc_r <= I_WDATA[SHC_W-1:0];
      // bytes above the operand size are left alone
      if (shift_live) shv_r <= (shv_r & ~shm) | shf.res;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      flg_r <= '0;
    end else begin
      if (sw_wr && I_ADDR == OFF_FLAGS) flg_r <= I_WDATA[7:0];
      // only C, Z and S move; long size Z and C are not meaningful
      if (shift_live) begin
        flg_r[FLG_C] <= shf.carry;
        flg_r[FLG_Z] <= shf.zero;
        flg_r[FLG_S] <= shf.msb;
      end
    end
  end

  // ---------------------------------------------------------------
  // string pointers
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      bank_r <= '0;
      src_r <= '0;
      dst_r <= '0;
      cnt_r <= '0;
      fill_r <= '0;
    end else begin
      if (sw_wr && I_ADDR == OFF_BANK) bank_r <= I_WDATA[BANK_W-1:0];
      if (sw_wr && I_ADDR == OFF_SRC) src_r <= I_WDATA;
      if (sw_wr && I_ADDR == OFF_DST) dst_r <= I_WDATA;
      if (sw_wr && I_ADDR == OFF_COUNT) cnt_r <= I_WDATA;
      if (sw_wr && I_ADDR == OFF_FILL) fill_r <= I_WDATA;
      if (step_src) begin
        src_r <= src_nxt;
        bank_r <= bank_nxt;
      end
      if (step_dst) begin
        dst_r <= dst_nxt;
        cnt_r <= cnt_r - CNT_ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer and memory port
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_r <= S_IDLE;
      O_MEM_RD <= 1'b0;
      O_MEM_WR <= 1'b0;
      O_MEM_WORD <= 1'b0;
      O_MEM_ADDR <= '0;
      O_MEM_WDATA <= '0;
      O_IRQ_ACK <= 1'b0;
      O_BUSY <= 1'b0;
      first_r <= 1'b0;
      bidx_r <= '0;
      susp_r <= 1'b0;
      done_r <= 1'b0;
      cres_r <= '0;
    end else begin
      O_MEM_RD <= 1'b0;
      O_MEM_WR <= 1'b0;
      O_IRQ_ACK <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (start) begin
            susp_r <= 1'b0;
            done_r <= 1'b0;
            first_r <= 1'b1;
            bidx_r <= '0;
            unique case (cmd_op)
              OP_SHIFT: begin
                state_r <= S_SHIFT;
                O_BUSY <= 1'b1;
              end
              OP_COPY_DN, OP_COPY_UP, OP_FILL: begin
                state_r <= S_NEXT;
                O_BUSY <= 1'b1;
              end
              OP_CREG: begin
                state_r <= S_STORE;
                O_BUSY <= 1'b1;
              end
              default: done_r <= 1'b1;
            endcase
          end
        end
        S_SHIFT: begin
          state_r <= S_IDLE;
          O_BUSY <= 1'b0;
          done_r <= 1'b1;
        end
        S_NEXT: begin
          first_r <= 1'b0;
          if (cnt_r == CNT_ZERO) begin
            state_r <= S_IDLE;
            O_BUSY <= 1'b0;
            done_r <= 1'b1;
          end else if (irq_take) begin
            state_r <= S_IDLE;
            O_BUSY <= 1'b0;
            susp_r <= 1'b1;
            O_IRQ_ACK <= 1'b1;
          end else if (op_r == OP_FILL) begin
            O_MEM_WR <= 1'b1;
            O_MEM_WORD <= wide;
            O_MEM_ADDR <= MEM_AW'(dst_r);
            O_MEM_WDATA <= wide ? fill_r : DATA_W'(fill_r[BYTE_W-1:0]);
          end else begin
            O_MEM_RD <= 1'b1;
            O_MEM_WORD <= wide;
            O_MEM_ADDR <= {bank_r, src_r};
            state_r <= S_READ;
          end
        end
        S_READ: state_r <= S_XFER;
        S_XFER: begin
          O_MEM_WR <= 1'b1;
          O_MEM_ADDR <= MEM_AW'(dst_r);
          O_MEM_WDATA <= wide ? I_MEM_RDATA : DATA_W'(I_MEM_RDATA[BYTE_W-1:0]);
          state_r <= S_NEXT;
        end
        S_STORE: begin
          if (!memdst_r) begin
            cres_r <= creg_val[MEM_AW-1:0];
            state_r <= S_IDLE;
            O_BUSY <= 1'b0;
            done_r <= 1'b1;
          end else begin
            O_MEM_WR <= 1'b1;
            O_MEM_WORD <= 1'b0;
            O_MEM_ADDR <= MEM_AW'(dst_r) + MEM_AW'(bidx_r);
            O_MEM_WDATA <= DATA_W'(creg_val[BYTE_W*bidx_r +: BYTE_W]);
            bidx_r <= bidx_r + BIDX_ONE;
            if (bidx_r == nbytes - BIDX_ONE) begin
              state_r <= S_IDLE;
              O_BUSY <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
          O_BUSY <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  sequence copy_elem_s;
    O_MEM_RD && !O_MEM_WR ##1 !O_MEM_RD && !O_MEM_WR ##1 O_MEM_WR && !O_MEM_RD;
  endsequence

  sequence quiet2_s;
    (!O_MEM_RD && !O_MEM_WR) [*2];
  endsequence

  left_shift_a: assert property (
    state_r == S_SHIFT && shc_r == 8'h01 && size_r == SZ_B
    |=> shv_r[7:0] == {$past(shv_r[6:0]), 1'b0} && flg_r[FLG_C] == $past(shv_r[7]))
    else $error("byte left shift wrong");
  right_shift_a: assert property (
    state_r == S_SHIFT && shc_r == 8'hff && size_r == SZ_W
    |=> shv_r[15:0] == {1'b0, $past(shv_r[15:1])} && flg_r[FLG_C] == $past(shv_r[0]))
    else $error("word right shift wrong");
  zero_shift_a: assert property (
    state_r == S_SHIFT && shc_r == SHC_ZERO |=> $stable(shv_r) && $stable(flg_r))
    else $error("zero count shift changed state");
  shift_flags_a: assert property (
    shift_live && size_r != SZ_L
    |=> flg_r[FLG_Z] == ((shv_r & sse_mask(size_r)) == '0) && flg_r[FLG_S] == shv_r[sse_bits(size_r)-1])
    else $error("shift sign or zero flag wrong");
  keep_flags_a: assert property (
    state_r == S_SHIFT |=> (flg_r & FLG_KEEP_SHIFT) == ($past(flg_r) & FLG_KEEP_SHIFT))
    else $error("shift touched undefined flags");
  string_flags_a: assert property (
    state_r inside {S_NEXT, S_READ, S_XFER, S_STORE} |=> $stable(flg_r))
    else $error("string or store changed flags");
  copy_seq_a: assert property (
    issue && op_r != OP_FILL |=> copy_elem_s ##0 O_MEM_WDATA == (wide ? $past(I_MEM_RDATA) :
      DATA_W'($past(I_MEM_RDATA[7:0]))))
    else $error("copy element sequence wrong");
  src_addr_a: assert property (
    O_MEM_RD |-> O_MEM_ADDR == {bank_r, src_r})
    else $error("source address not bank and pointer");
  count_step_a: assert property (
    step_dst |=> cnt_r == $past(cnt_r) - CNT_ONE && dst_r != $past(dst_r))
    else $error("count or destination did not step");
  bank_wrap_a: assert property (
    step_src && op_r == OP_COPY_UP && src_r == 16'hffff && !wide |=> bank_r == $past(bank_r) + 4'h1 && src_r == '0)
    else $error("bank did not carry on wrap");
  zero_count_a: assert property (
    start && cmd_op inside {OP_COPY_DN, OP_COPY_UP, OP_FILL} && cnt_r == CNT_ZERO |=> quiet2_s ##1 !O_BUSY)
    else $error("zero count string moved data");
  irq_stop_a: assert property (
    state_r == S_NEXT && irq_take |=> O_IRQ_ACK && !O_BUSY && !O_MEM_RD && $stable(cnt_r))
    else $error("interrupt not taken at boundary");
  pc_bytes_a: assert property (
    start && cmd_op == OP_CREG && I_WDATA[CTRL_MEMDST] && I_WDATA[CTRL_SEL_LSB +: CTRL_SEL_W] == CR_PC
    |=> ##1 O_MEM_WR [*3] ##1 !O_MEM_WR)
    else $error("program counter store not three bytes");
endmodule

/* File: include/sse_pkg.sv */
package sse_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int MEM_AW = 20;
  localparam int BANK_W = 4;
  localparam int HI_W = 4;
  localparam int SHV_W = 32;
  localparam int SHC_W = 8;
  localparam int CTL_N = 8;
  localparam int BYTE_W = 8;
  localparam int SZ_B_BITS = 8;
  localparam int SZ_W_BITS = 16;
  localparam int SZ_L_BITS = 32;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h01;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 6'h02;
  localparam logic [ADDR_W-1:0] OFF_BANK = 6'h03;
  localparam logic [ADDR_W-1:0] OFF_SRC = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_DST = 6'h05;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 6'h06;
  localparam logic [ADDR_W-1:0] OFF_FILL = 6'h07;
  localparam logic [ADDR_W-1:0] OFF_SHV_LO = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_SHV_HI = 6'h09;
  localparam logic [ADDR_W-1:0] OFF_SHC = 6'h0a;
  localparam logic [ADDR_W-1:0] OFF_CRES_LO = 6'h0b;
  localparam logic [ADDR_W-1:0] OFF_CRES_HI = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_CTL_BASE = 6'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_SIZE_LSB = 3;
  localparam int CTRL_SIZE_W = 2;
  localparam int CTRL_MEMDST = 5;
  localparam int CTRL_SEL_LSB = 8;
  localparam int CTRL_SEL_W = 3;
  localparam int CTRL_START = 15;
  localparam int ST_BUSY = 0;
  localparam int ST_SUSP = 1;
  localparam int ST_DONE = 2;
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam logic [7:0] FLG_KEEP_SHIFT = 8'hf2;
  localparam int CI_FB = 0;
  localparam int CI_SB = 1;
  localparam int CI_USP = 2;
  localparam int CI_ISP = 3;
  localparam int CI_VECTOR_TABLE_BASE_LOW = 4;
  localparam int CI_VECTOR_TABLE_BASE_HIGH = 5;
  localparam int CI_PC_LO = 6;
  localparam int CI_PC_HI = 7;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [15:0] STEP_B = 16'h0001;
  localparam logic [15:0] STEP_W = 16'h0002;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] BYTES_PC = 2'h3;
  localparam logic [1:0] BYTES_OTHER = 2'h2;
  localparam logic [1:0] BIDX_ONE = 2'h1;
  localparam logic [SHC_W-1:0] SHC_ZERO = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_SHIFT = 3'h1, OP_COPY_DN = 3'h2,
    OP_COPY_UP = 3'h3, OP_FILL = 3'h4, OP_CREG = 3'h5
  } sse_op_t;
  typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} sse_size_t;
  typedef enum logic [2:0] {
    CR_FB = 3'h0, CR_SB = 3'h1, CR_SP = 3'h2, CR_ISP = 3'h3,
    CR_FLG = 3'h4, CR_VECTOR_TABLE_BASE_HIGH = 3'h5, CR_VECTOR_TABLE_BASE_LOW = 3'h6, CR_PC = 3'h7
  } sse_creg_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_SHIFT = 3'h1, S_NEXT = 3'h2,
    S_READ = 3'h3, S_XFER = 3'h4, S_STORE = 3'h5
  } sse_state_t;

  function automatic int sse_bits(input sse_size_t s);
    unique case (s)
      SZ_B: return SZ_B_BITS;
      SZ_W: return SZ_W_BITS;
      default: return SZ_L_BITS;
    endcase
  endfunction

  function automatic logic [SHV_W-1:0] sse_mask(input sse_size_t s);
    unique case (s)
      SZ_B: return 32'h0000_00ff;
      SZ_W: return 32'h0000_ffff;
      default: return 32'hffff_ffff;
    endcase
  endfunction
endpackage

/* File: include/sse_shf_if.sv */
interface sse_shf_if;
  import sse_pkg::*;
  logic [SHV_W-1:0] val;
  logic [SHC_W-1:0] cnt;
  sse_size_t size;
  logic [SHV_W-1:0] res;
  logic carry;
  logic msb;
  logic zero;
  modport user (output val, output cnt, output size, input res, input carry, input msb, input zero);
  modport unit (input val, input cnt, input size, output res, output carry, output msb, output zero);
endinterface

/* File: rtl/sse_shift.sv */
module sse_shift (
  sse_shf_if.unit sif
);
  import sse_pkg::*;

  // ---------------------------------------------------------------
  // barrel shift, zero fill both ways
  // ---------------------------------------------------------------
  logic [SHV_W-1:0] v;
  logic [SHV_W-1:0] m;
  logic [SHV_W+SZ_W_BITS-1:0] lt;
  logic [SHV_W+SZ_W_BITS-1:0] rt;
  logic [4:0] n;
  logic neg;
  int w;

  always_comb begin
    m = sse_mask(sif.size);
    w = sse_bits(sif.size);
    v = sif.val & m;
    neg = sif.cnt[SHC_W-1];
    // counts beyond the legal magnitude give an undefined result anyway
    n = neg ? 5'(-sif.cnt) : 5'(sif.cnt);
    lt = {16'h0000, v} << n;
    rt = {v, 16'h0000} >> n;
    if (neg) begin
      sif.res = rt[SHV_W+SZ_W_BITS-1:SZ_W_BITS] & m;
      sif.carry = rt[SZ_W_BITS-1];
    end else begin
      sif.res = lt[SHV_W-1:0] & m;
      sif.carry = lt[w];
    end
    sif.msb = sif.res[w-1];
    sif.zero = sif.res == '0;
  end
endmodule

/* File: rtl/sse_step.sv */
module sse_step #(
  parameter int PW = 16,
  parameter int BW = 4
) (
  input wire logic [PW-1:0] i_ptr,
  input wire logic [BW-1:0] i_bank,
  input wire logic i_down,
  input wire logic i_wide,
  output logic [PW-1:0] o_ptr,
  output logic [BW-1:0] o_bank
);
  import sse_pkg::*;

  logic [PW:0] sum;
  logic [PW-1:0] step;

  always_comb begin
    step = i_wide ? PW'(STEP_W) : PW'(STEP_B);
    sum = i_down ? ({1'b0, i_ptr} - {1'b0, step}) : ({1'b0, i_ptr} + {1'b0, step});
    o_ptr = sum[PW-1:0];
    o_bank = i_bank;
    // the spare bit flags a wrap either way, so it carries into the bank
    if (sum[PW]) begin
      o_bank = i_down ? i_bank - BW'(1) : i_bank + BW'(1);
    end
  end
endmodule

/* File: bench/test_shift_string_store_exec.sv */
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_shift_string_store_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import sse_pkg::*;
  logic I_CLK_SYS = 0, I_RSTN = 0, I_WR = 0, I_RD = 0, I_IRQ = 0;
  logic [ADDR_W-1:0] I_ADDR = 6'h00;
  logic [DATA_W-1:0] I_WDATA = 16'h0000, I_MEM_RDATA = 16'h0000, O_RDATA, O_MEM_WDATA, ld;
  logic [MEM_AW-1:0] O_MEM_ADDR, la;
  logic O_MEM_RD, O_MEM_WR, O_MEM_WORD, O_IRQ_ACK, O_BUSY, lw;
  int num_errors = 0, n_compared = 0, nwr = 0, nack = 0;
  sse_exec dut (.I_CLK_SYS, .I_RSTN, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_MEM_ADDR, .O_MEM_RD,
    .O_MEM_WR, .O_MEM_WORD, .O_MEM_WDATA, .I_MEM_RDATA, .I_IRQ, .O_IRQ_ACK, .O_BUSY);
  initial forever #4 I_CLK_SYS = ~I_CLK_SYS;
  // ---------------------------------------------------------------
  // memory side and access helpers
  // ---------------------------------------------------------------
  // idle read data toggles so a late sample never looks valid
  always @(posedge I_CLK_SYS) begin
    I_MEM_RDATA <= O_MEM_RD ? O_MEM_ADDR[15:0] ^ 16'h3c3c : ~I_MEM_RDATA;
    if (O_MEM_WR === 1'b1) begin
      nwr++;
      la <= O_MEM_ADDR;
      ld <= O_MEM_WDATA;
      lw <= O_MEM_WORD;
    end
    if (O_IRQ_ACK === 1'b1) nack++;
  end
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    summarize;
  end
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge I_CLK_SYS);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
    @(posedge I_CLK_SYS);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
    #1;
    `CHK(n, e, O_RDATA & m)
  endtask
  function automatic logic [15:0] cw(input logic [2:0] op, input logic [1:0] z, input logic md, input logic [2:0] s);
    return {1'b1, 4'h0, s, 2'h0, md, z, op};
  endfunction
  // bounded wait; busy must fall long before the limit
  task run(input logic [15:0] c);
    int i;
    wr(OFF_CTRL, c);
    for (i = 0; i < 400; i++) begin
      @(posedge I_CLK_SYS);
      #1;
      if (O_BUSY === 1'b0) break;
    end
    // a last store strobe or ack can share the edge that drops busy
    @(posedge I_CLK_SYS);
    #1;
    `CHK("busy", 1'b0, O_BUSY)
  endtask
  task go(input logic [3:0] b, input logic [15:0] s, input logic [15:0] d, input logic [15:0] n, input logic [15:0] c);
    wr(OFF_BANK, {12'h000, b});
    wr(OFF_SRC, s);
    wr(OFF_DST, d);
    wr(OFF_COUNT, n);
    nwr = 0;
    nack = 0;
    run(c);
  endtask
  task st(input logic [3:0] b, input logic [15:0] s, input logic [15:0] d, input logic [15:0] n, input logic [7:0] f);
    rd(OFF_BANK, 16'h000f, {12'h000, b}, "bank");
    rd(OFF_SRC, 16'hffff, s, "src");
    rd(OFF_DST, 16'hffff, d, "dst");
    rd(OFF_COUNT, 16'hffff, n, "count");
    rd(OFF_FLAGS, 16'h00ff, {8'h00, f}, "flags");
  endtask
  task mw(input int n, input logic [19:0] a, input logic [15:0] d);
    `CHK("writes", n, nwr)
    `CHK("waddr", a, la)
    `CHK("wdata", d, ld)
  endtask
  task sh(input logic [1:0] z, input logic [15:0] v, input logic [7:0] c, input logic [15:0] e, input logic [7:0] f);
    wr(OFF_FLAGS, 16'h00f0);
    wr(OFF_SHV_LO, v);
    wr(OFF_SHV_HI, 16'h0000);
    wr(OFF_SHC, {8'h00, c});
    run(cw(OP_SHIFT, z, 1'b0, 3'h0));
    rd(OFF_SHV_LO, z == SZ_B ? 16'h00ff : 16'hffff, e, "shift result");
    rd(OFF_FLAGS, 16'h00ff, {8'h00, f}, "shift flags");
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge I_CLK_SYS);
    I_RSTN <= 1'b1;
    sh(SZ_B, 16'h0081, 8'h01, 16'h0002, 8'hf1);
    sh(SZ_B, 16'h0081, 8'h08, 16'h0000, 8'hf5);
    sh(SZ_W, 16'h8000, 8'hf0, 16'h0000, 8'hf5);
    sh(SZ_W, 16'h0003, 8'hff, 16'h0001, 8'hf1);
    sh(SZ_B, 16'h0080, 8'h00, 16'h0080, 8'hf0);
    sh(SZ_W, 16'h4000, 8'h01, 16'h8000, 8'hf8);
    $display("test shift done");
    go(4'h0, 16'hffff, 16'h0100, 16'h0002, cw(OP_COPY_UP, SZ_B, 1'b0, 3'h0));
    mw(2, 20'h00101, 16'h003c);
    `CHK("byte access", 1'b0, lw)
    st(4'h1, 16'h0001, 16'h0102, 16'h0000, 8'hf8);
    go(4'h1, 16'h0000, 16'h0200, 16'h0001, cw(OP_COPY_DN, SZ_W, 1'b0, 3'h0));
    mw(1, 20'h00200, 16'h3c3c);
    `CHK("word access", 1'b1, lw)
    st(4'h0, 16'hfffe, 16'h01fe, 16'h0000, 8'hf8);
    $display("test copy done");
    wr(OFF_FILL, 16'h12ab);
    go(4'h0, 16'h0000, 16'h0300, 16'h0003, cw(OP_FILL, SZ_B, 1'b0, 3'h0));
    mw(3, 20'h00302, 16'h00ab);
    st(4'h0, 16'h0000, 16'h0303, 16'h0000, 8'hf8);
    go(4'h0, 16'h0000, 16'h0300, 16'h0000, cw(OP_COPY_UP, SZ_W, 1'b0, 3'h0));
    `CHK("zero count writes", 0, nwr)
    st(4'h0, 16'h0000, 16'h0300, 16'h0000, 8'hf8);
    $display("test fill done");
    I_IRQ <= 1'b1;
    go(4'h0, 16'h0010, 16'h0500, 16'h0004, cw(OP_COPY_UP, SZ_B, 1'b0, 3'h0));
    `CHK("acks", 1, nack)
    st(4'h0, 16'h0011, 16'h0501, 16'h0003, 8'hf8);
    rd(OFF_STATUS, 16'h0007, 16'h0002, "status");
    I_IRQ <= 1'b0;
    repeat (4) @(posedge I_CLK_SYS);
    run(cw(OP_COPY_UP, SZ_B, 1'b0, 3'h0));
    st(4'h0, 16'h0014, 16'h0504, 16'h0000, 8'hf8);
    `CHK("resumed writes", 4, nwr)
    $display("test interrupt done");
    wr(6'h16, 16'h4321);
    wr(6'h17, 16'h0005);
    wr(6'h10, 16'hbeef);
    wr(6'h12, 16'h1111);
    wr(6'h13, 16'h2222);
    go(4'h0, 16'h0000, 16'h0400, 16'h0000, cw(OP_CREG, SZ_B, 1'b1, CR_PC));
    mw(3, 20'h00402, 16'h0005);
    go(4'h0, 16'h0000, 16'h0400, 16'h0000, cw(OP_CREG, SZ_B, 1'b1, CR_FB));
    mw(2, 20'h00401, 16'h00be);
    run(cw(OP_CREG, SZ_W, 1'b0, CR_SP));
    rd(OFF_CRES_LO, 16'hffff, 16'h1111, "user stack");
    wr(OFF_FLAGS, 16'h0078);
    run(cw(OP_CREG, SZ_W, 1'b0, CR_SP));
    rd(OFF_CRES_LO, 16'hffff, 16'h2222, "irq stack");
    rd(OFF_FLAGS, 16'h00ff, 16'h0078, "store flags");
    run(cw(OP_CREG, SZ_W, 1'b0, CR_FLG));
    rd(OFF_CRES_LO, 16'hffff, 16'h0078, "flag store");
    $display("test control store done");
    summarize;
  end
endmodule
